/* hdl/oms_pkg.sv */
package oms_pkg;

	localparam logic [15:0] RAM_BASE     = 16'h0000;
	localparam logic [15:0] RAM_LAST     = 16'h03FF;
	localparam logic [15:0] EE_BASE      = 16'hFE00;
	localparam logic [15:0] ROM_BASE     = 16'hBF00;
	localparam logic [15:0] ROM_LAST     = 16'hBFFF;
	localparam logic [15:0] VEC_BASE     = 16'hFFC0;
	localparam logic [7:0]  ROM_VEC_IDX  = 8'hC0;
	localparam logic [7:0]  RST_VEC_IDX  = 8'hFE;
	localparam logic [15:0] LOADER_ENTRY = 16'hBF00;
	localparam logic [15:0] JT_BASE      = 16'h00C4;
	localparam logic [15:0] LOAD_START   = 16'h0000;
	localparam logic [15:0] CFG_ADDR     = 16'h103F;
	localparam logic [7:0]  ROM_FILL     = 8'h01;
	localparam logic [7:0]  CFG_RST      = 8'h01;
	localparam int          CFG_EE_BIT   = 0;
	localparam int          RAM_AW       = 10;
	localparam int          EE_AW        = 9;
	localparam int          SYNC_LEN     = 3;
	localparam int          EXT_WAIT     = 6;

	// One character is ten bit times at 7812.5 bit/s.
	localparam int          CHAR_TIME_NS  = 1280000;
	localparam int          IDLE_CHARS    = 4;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          IDLE_CYCLES   =
		(IDLE_CHARS * (CHAR_TIME_NS / 1000) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		MODE_BOOT   = 4'b0001,
		MODE_TEST   = 4'b0010,
		MODE_SINGLE = 4'b0100,
		MODE_EXP    = 4'b1000
	} oms_mode_e;

	localparam oms_mode_e MODE_RST = MODE_SINGLE;

	typedef enum logic [5:0] {
		SEL_NONE = 6'b000001,
		SEL_RAM  = 6'b000010,
		SEL_EE   = 6'b000100,
		SEL_ROM  = 6'b001000,
		SEL_CFG  = 6'b010000,
		SEL_EXT  = 6'b100000
	} oms_sel_e;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} oms_req_s;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
	} oms_pin_s;

endpackage

/* hdl/oms_mem.sv */
`timescale 1ns/1ps
module oms_mem #(
	parameter int AW = 10
) (
	input  wire logic          ref_clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [7:0]    wdata_in,
	output logic [7:0]         rdata_out
);

	logic [7:0] mem_r [0:(1<<AW)-1];

	always_ff @(posedge ref_clk_in) begin
		if (we_in) begin
			mem_r[addr_in] <= wdata_in;
		end
		rdata_out <= mem_r[addr_in];
	end

endmodule

/* hdl/oms_top.sv */
`timescale 1ns/1ps
module oms_top #(
	parameter int IDLE_CYCLES = oms_pkg::IDLE_CYCLES
) (
	input  wire logic              ref_clk_in,
	input  wire logic              resetn_in,
	input  wire logic              mode_sel_hi_in,
	input  wire logic              mode_sel_lo_in,
	input  wire logic              cpu_req_valid_in,
	input  wire oms_pkg::oms_req_s cpu_req_in,
	output logic                   cpu_ready_out,
	output logic                   cpu_done_out,
	output logic [7:0]             cpu_rdata_out,
	output logic                   cpu_hold_out,
	output logic [15:0]            start_pc_out,
	output logic                   start_valid_out,
	output logic [15:0]            loader_entry_out,
	output logic                   async_serial_unit_en_out,
	input  wire logic              rx_valid_in,
	input  wire logic [7:0]        rx_data_in,
	output logic                   portd_wired_or_out,
	output oms_pkg::oms_mode_e     mode_out,
	output logic [7:0]             config_out,
	input  wire oms_pkg::oms_pin_s gpio_b_in,
	input  wire oms_pkg::oms_pin_s gpio_c_in,
	input  wire oms_pkg::oms_pin_s gpio_f_in,
	output oms_pkg::oms_pin_s      portb_out,
	output oms_pkg::oms_pin_s      portc_out,
	output oms_pkg::oms_pin_s      portf_out,
	input  wire logic [7:0]        portc_in,
	output logic [7:0]             portc_sync_out,
	output logic                   rw_out
);

	typedef enum logic [3:0] {
		B_IDLE = 4'b0001,
		B_MEM  = 4'b0010,
		B_EXT  = 4'b0100,
		B_DONE = 4'b1000
	} oms_bus_e;

	typedef enum logic [3:0] {
		L_VEC  = 4'b0001,
		L_WAIT = 4'b0010,
		L_LOAD = 4'b0100,
		L_RUN  = 4'b1000
	} oms_ld_e;

	localparam int EXT_LAT = oms_pkg::EXT_WAIT + 1;

	function automatic oms_pkg::oms_mode_e mode_of(input logic [1:0] pins);
		case (pins)
			2'b00:   mode_of = oms_pkg::MODE_BOOT;
			2'b01:   mode_of = oms_pkg::MODE_TEST;
			2'b10:   mode_of = oms_pkg::MODE_SINGLE;
			default: mode_of = oms_pkg::MODE_EXP;
		endcase
	endfunction

	function automatic oms_pkg::oms_sel_e decode(input oms_pkg::oms_mode_e m,
		input logic [15:0] a, input logic ee_on);
		logic boot;
		logic ext;
		boot = (m == oms_pkg::MODE_BOOT);
		ext  = (m == oms_pkg::MODE_EXP) || (m == oms_pkg::MODE_TEST);
		if (boot && a >= oms_pkg::VEC_BASE) begin
			decode = oms_pkg::SEL_ROM;
		end else if (boot && a >= oms_pkg::ROM_BASE && a <= oms_pkg::ROM_LAST) begin
			decode = oms_pkg::SEL_ROM;
		end else if (a == oms_pkg::CFG_ADDR) begin
			decode = oms_pkg::SEL_CFG;
		end else if (a <= oms_pkg::RAM_LAST) begin
			decode = oms_pkg::SEL_RAM;
		end else if (a >= oms_pkg::EE_BASE && (!ext || ee_on)) begin
			decode = oms_pkg::SEL_EE;
		end else if (ext) begin
			decode = oms_pkg::SEL_EXT;
		end else begin
			decode = oms_pkg::SEL_NONE;
		end
	endfunction

	// Vectors are big-endian pairs; every vector but reset lands in a
	// three-byte jump slot in RAM.
	function automatic logic [7:0] rom_byte(input logic [7:0] idx);
		logic [15:0] tgt;
		tgt = oms_pkg::JT_BASE + 16'(3 * idx[5:1]);
		if (idx[7:1] == oms_pkg::RST_VEC_IDX[7:1]) begin
			tgt = oms_pkg::LOADER_ENTRY;
		end
		if (idx < oms_pkg::ROM_VEC_IDX) begin
			rom_byte = oms_pkg::ROM_FILL;
		end else begin
			rom_byte = idx[0] ? tgt[7:0] : tgt[15:8];
		end
	endfunction

	logic [1:0]         mode_s1_r, mode_s2_r, mode_s3_r, pins_r;
	logic [7:0]         pc_s1_r, pc_s2_r, pc_s3_r;
	oms_pkg::oms_mode_e mode_r;
	oms_bus_e           bus_st;
	oms_ld_e            ld_st;
	oms_pkg::oms_sel_e  req_sel, sel_r;
	logic               take;
	logic               ext_mode;
	logic [15:0]        ext_addr_r;
	logic               ext_we_r;
	logic [7:0]         ext_wdata_r;
	logic [3:0]         ext_cnt_r;
	logic [7:0]         rom_q_r;
	logic [7:0]         rdata_r;
	logic [7:0]         config_r;
	logic [15:0]        load_addr_r;
	logic [31:0]        idle_cnt_r;
	logic [15:0]        boot_vec_r;
	logic               start_r;
	logic               wired_r;
	logic               ram_we, ee_we;
	logic [9:0]         ram_addr;
	logic [7:0]         ram_wdata, ram_q, ee_q;
	oms_pkg::oms_pin_s  pb_nxt, pc_nxt, pf_nxt, pb_r, pc_r, pf_r;
	logic               rw_nxt, rw_r;

	// Three-stage pin synchronisers.
	always_ff @(posedge ref_clk_in) begin
		mode_s1_r <= {mode_sel_hi_in, mode_sel_lo_in};
		mode_s2_r <= mode_s1_r;
		mode_s3_r <= mode_s2_r;
		pc_s1_r   <= portc_in;
		pc_s2_r   <= pc_s1_r;
		pc_s3_r   <= pc_s2_r;
	end

	// The settled pins are not reset, since the mode must be taken from them while reset is held.
	always_ff @(posedge ref_clk_in) begin
		if (mode_s2_r == mode_s3_r) begin
			pins_r <= mode_s3_r;
		end
	end

	// The mode follows the pins only while reset is held.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			mode_r <= mode_of(pins_r);
		end
	end

	assign ext_mode = (mode_r == oms_pkg::MODE_EXP) || (mode_r == oms_pkg::MODE_TEST);
	assign req_sel  = decode(mode_r, cpu_req_in.addr, config_r[oms_pkg::CFG_EE_BIT]);
	assign cpu_ready_out = (bus_st == B_IDLE) && (ld_st == L_RUN);
	assign take = cpu_ready_out && cpu_req_valid_in;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			bus_st    <= B_IDLE;
			sel_r     <= oms_pkg::SEL_NONE;
			ext_cnt_r <= 4'h0;
		end else begin
			case (bus_st)
				B_IDLE: begin
					if (take) begin
						sel_r     <= req_sel;
						ext_cnt_r <= 4'h0;
						bus_st    <= (req_sel == oms_pkg::SEL_EXT) ? B_EXT : B_MEM;
					end
				end
				B_MEM: begin
					bus_st <= B_DONE;
				end
				B_EXT: begin
					ext_cnt_r <= ext_cnt_r + 4'h1;
					if (ext_cnt_r == 4'(oms_pkg::EXT_WAIT - 1)) begin
						bus_st <= B_DONE;
					end
				end
				default: begin
					bus_st <= B_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			ext_addr_r  <= 16'h0000;
			ext_we_r    <= 1'b0;
			ext_wdata_r <= 8'h00;
		end else if (take && req_sel == oms_pkg::SEL_EXT) begin
			ext_addr_r  <= cpu_req_in.addr;
			ext_we_r    <= cpu_req_in.we;
			ext_wdata_r <= cpu_req_in.wdata;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rom_q_r <= 8'h00;
		end else if (take) begin
			rom_q_r <= rom_byte(cpu_req_in.addr[7:0]);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rdata_r <= 8'h00;
		end else if (bus_st == B_MEM) begin
			case (sel_r)
				oms_pkg::SEL_RAM: rdata_r <= ram_q;
				oms_pkg::SEL_EE:  rdata_r <= ee_q;
				oms_pkg::SEL_ROM: rdata_r <= rom_q_r;
				oms_pkg::SEL_CFG: rdata_r <= config_r;
				default:          rdata_r <= 8'h00;
			endcase
		end else if (bus_st == B_EXT && ext_cnt_r == 4'(oms_pkg::EXT_WAIT - 1)) begin
			rdata_r <= ext_we_r ? 8'h00 : pc_s3_r;
		end
	end

	assign cpu_done_out  = (bus_st == B_DONE);
	assign cpu_rdata_out = rdata_r;

	// Only test mode may rewrite the configuration byte.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			config_r <= oms_pkg::CFG_RST;
		end else if (take && cpu_req_in.we && req_sel == oms_pkg::SEL_CFG
			&& mode_r == oms_pkg::MODE_TEST) begin
			config_r <= cpu_req_in.wdata;
		end
	end

	assign config_out = config_r;
	assign mode_out   = mode_r;

	// Loader sequencer; outside bootstrap it releases the core at once.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			ld_st       <= L_VEC;
			load_addr_r <= oms_pkg::LOAD_START;
			idle_cnt_r  <= 32'h00000000;
			boot_vec_r  <= 16'h0000;
			start_r     <= 1'b0;
		end else begin
			start_r <= 1'b0;
			case (ld_st)
				L_VEC: begin
					boot_vec_r <= {rom_byte(oms_pkg::RST_VEC_IDX),
						rom_byte(oms_pkg::RST_VEC_IDX + 8'h01)};
					ld_st <= (mode_r == oms_pkg::MODE_BOOT) ? L_WAIT : L_RUN;
				end
				L_WAIT: begin
					if (rx_valid_in) begin
						ld_st <= L_LOAD;
					end
				end
				L_LOAD: begin
					if (rx_valid_in) begin
						idle_cnt_r  <= 32'h00000000;
						load_addr_r <= load_addr_r + 16'h0001;
						if (load_addr_r == oms_pkg::RAM_LAST) begin
							ld_st   <= L_RUN;
							start_r <= 1'b1;
						end
					end else if (idle_cnt_r == 32'(IDLE_CYCLES - 1)) begin
						ld_st   <= L_RUN;
						start_r <= 1'b1;
					end else begin
						idle_cnt_r <= idle_cnt_r + 32'h00000001;
					end
				end
				default: begin
					ld_st <= L_RUN;
				end
			endcase
		end
	end

	assign cpu_hold_out             = (ld_st != L_RUN);
	assign start_valid_out          = start_r;
	assign start_pc_out             = oms_pkg::LOAD_START;
	assign loader_entry_out         = boot_vec_r;
	assign async_serial_unit_en_out = (ld_st == L_WAIT) || (ld_st == L_LOAD);

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			wired_r <= 1'b0;
		end else if (mode_r == oms_pkg::MODE_BOOT && ld_st != L_VEC) begin
			wired_r <= 1'b1;
		end
	end

	assign portd_wired_or_out = wired_r;

	// The loader owns the RAM port while the core is held.
	always_comb begin
		if (cpu_hold_out) begin
			ram_we    = (ld_st == L_LOAD) && rx_valid_in;
			ram_addr  = load_addr_r[9:0];
			ram_wdata = rx_data_in;
		end else begin
			ram_we    = take && cpu_req_in.we && req_sel == oms_pkg::SEL_RAM;
			ram_addr  = cpu_req_in.addr[9:0];
			ram_wdata = cpu_req_in.wdata;
		end
	end

	assign ee_we = take && cpu_req_in.we && req_sel == oms_pkg::SEL_EE;

	oms_mem #(.AW(oms_pkg::RAM_AW)) u_ram (
		.ref_clk_in (ref_clk_in),
		.we_in      (ram_we),
		.addr_in    (ram_addr),
		.wdata_in   (ram_wdata),
		.rdata_out  (ram_q)
	);

	oms_mem #(.AW(oms_pkg::EE_AW)) u_ee (
		.ref_clk_in (ref_clk_in),
		.we_in      (ee_we),
		.addr_in    (cpu_req_in.addr[8:0]),
		.wdata_in   (cpu_req_in.wdata),
		.rdata_out  (ee_q)
	);

	always_comb begin
		if (ext_mode) begin
			pb_nxt = '{data: ext_addr_r[15:8], oe: 8'hFF};
			pf_nxt = '{data: ext_addr_r[7:0], oe: 8'hFF};
			pc_nxt = '{data: ext_wdata_r, oe: 8'h00};
			rw_nxt = 1'b1;
			if (bus_st == B_EXT && ext_we_r) begin
				pc_nxt.oe = 8'hFF;
				rw_nxt    = 1'b0;
			end
		end else begin
			pb_nxt = gpio_b_in;
			pc_nxt = gpio_c_in;
			pf_nxt = gpio_f_in;
			rw_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			pb_r <= 16'h0000;
			pc_r <= 16'h0000;
			pf_r <= 16'h0000;
			rw_r <= 1'b1;
		end else begin
			pb_r <= pb_nxt;
			pc_r <= pc_nxt;
			pf_r <= pf_nxt;
			rw_r <= rw_nxt;
		end
	end

	assign portb_out      = pb_r;
	assign portc_out      = pc_r;
	assign portf_out      = pf_r;
	assign rw_out         = rw_r;
	assign portc_sync_out = pc_s3_r;

	sequence s_ext_take;
		take && req_sel == oms_pkg::SEL_EXT;
	endsequence

	sequence s_boot_vec_read;
		take && !cpu_req_in.we && mode_r == oms_pkg::MODE_BOOT
			&& cpu_req_in.addr == 16'hFFFE;
	endsequence

	property p_mode_cap;
		@(posedge ref_clk_in) (resetn_in && !$past(resetn_in))
			|-> mode_r == mode_of($past(pins_r));
	endproperty
	a_mode_cap: assert property (p_mode_cap) else $error("mode not taken from pins at reset");

	property p_mode_hold;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			$past(resetn_in) |-> $stable(mode_r);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

	property p_single_gpio;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(mode_r == oms_pkg::MODE_SINGLE && $past(resetn_in))
			|=> portb_out == $past(gpio_b_in) && rw_out;
	endproperty
	a_single_gpio: assert property (p_single_gpio) else $error("single-chip port B not GPIO");

	property p_ext_addr;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(bus_st == B_EXT && $past(bus_st) == B_EXT)
			|-> portb_out.data == ext_addr_r[15:8] && portf_out.data == ext_addr_r[7:0];
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("address not on ports B and F");

	property p_ext_dir;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(bus_st == B_EXT && $past(bus_st) == B_EXT)
			|-> rw_out == !ext_we_r && portc_out.oe == {8{ext_we_r}};
	endproperty
	a_ext_dir: assert property (p_ext_dir) else $error("direction strobe wrong");

	property p_ext_done;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			s_ext_take |-> ##EXT_LAT cpu_done_out;
	endproperty
	a_ext_done: assert property (p_ext_done) else $error("external access did not end");

	property p_boot_vec;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			s_boot_vec_read |-> ##2 cpu_done_out && cpu_rdata_out == 8'hBF;
	endproperty
	a_boot_vec: assert property (p_boot_vec) else $error("boot vector not from boot ROM");

	property p_rom_gate;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(cpu_done_out && sel_r == oms_pkg::SEL_ROM) |-> mode_r == oms_pkg::MODE_BOOT;
	endproperty
	a_rom_gate: assert property (p_rom_gate) else $error("boot ROM hit outside bootstrap");

	property p_cfg_lock;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(take && cpu_req_in.we && cpu_req_in.addr == oms_pkg::CFG_ADDR
				&& mode_r != oms_pkg::MODE_TEST) |=> $stable(config_r);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("config written outside test");

	property p_load_end;
		@(posedge ref_clk_in) disable iff (!resetn_in)
			(ld_st == L_LOAD && rx_valid_in && load_addr_r == oms_pkg::RAM_LAST)
			|=> start_valid_out && !cpu_hold_out ##1 !start_valid_out;
	endproperty
	a_load_end: assert property (p_load_end) else $error("loader did not start at last byte");

endmodule

/* test/oms_ext_mem.sv */
`timescale 1ns/1ps
module oms_ext_mem (
	input  wire logic              ref_clk_in,
	input  wire oms_pkg::oms_pin_s addr_hi_in,
	input  wire oms_pkg::oms_pin_s addr_lo_in,
	input  wire oms_pkg::oms_pin_s data_in,
	input  wire logic              rw_in,
	output logic [7:0]             data_out
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr;
	logic        sel;
	assign addr = {addr_hi_in.data, addr_lo_in.data};
	assign sel  = (addr_hi_in.oe == 8'hFF) && (addr_lo_in.oe == 8'hFF);
	initial data_out = 8'h00;
	always @(posedge ref_clk_in) begin
		if (sel && !rw_in && data_in.oe == 8'hFF) begin
			mem[addr] <= data_in.data;
		end
	end
	// An unaddressed bus toggles every cycle, so stale data never passes for a read.
	always @(posedge ref_clk_in) begin
		if (sel && rw_in) begin
			data_out <= mem[addr];
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule

/* test/tb_operating_mode_select.sv */
`timescale 1ns/1ps
module tb_operating_mode_select;
	localparam int IDLE = 50;
	logic              ref_clk_in;
	logic              resetn_in;
	logic              mode_sel_hi_in;
	logic              mode_sel_lo_in;
	logic              cpu_req_valid_in;
	oms_pkg::oms_req_s cpu_req_in;
	logic              cpu_ready_out;
	logic              cpu_done_out;
	logic [7:0]        cpu_rdata_out;
	logic              cpu_hold_out;
	logic [15:0]       start_pc_out;
	logic              start_valid_out;
	logic [15:0]       loader_entry_out;
	logic              async_serial_unit_en_out;
	logic              rx_valid_in;
	logic [7:0]        rx_data_in;
	logic              portd_wired_or_out;
	oms_pkg::oms_mode_e mode_out;
	logic [7:0]        config_out;
	oms_pkg::oms_pin_s gpio_b_in;
	oms_pkg::oms_pin_s gpio_c_in;
	oms_pkg::oms_pin_s gpio_f_in;
	oms_pkg::oms_pin_s portb_out;
	oms_pkg::oms_pin_s portc_out;
	oms_pkg::oms_pin_s portf_out;
	logic [7:0]        portc_in;
	logic [7:0]        portc_sync_out;
	logic              rw_out;
	int                errors;
	int                compares;

	oms_top #(.IDLE_CYCLES(IDLE)) u_oms_top (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.mode_sel_hi_in(mode_sel_hi_in), .mode_sel_lo_in(mode_sel_lo_in),
		.cpu_req_valid_in(cpu_req_valid_in), .cpu_req_in(cpu_req_in),
		.cpu_ready_out(cpu_ready_out), .cpu_done_out(cpu_done_out),
		.cpu_rdata_out(cpu_rdata_out), .cpu_hold_out(cpu_hold_out),
		.start_pc_out(start_pc_out), .start_valid_out(start_valid_out),
		.loader_entry_out(loader_entry_out),
		.async_serial_unit_en_out(async_serial_unit_en_out),
		.rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
		.portd_wired_or_out(portd_wired_or_out), .mode_out(mode_out),
		.config_out(config_out), .gpio_b_in(gpio_b_in), .gpio_c_in(gpio_c_in),
		.gpio_f_in(gpio_f_in), .portb_out(portb_out), .portc_out(portc_out),
		.portf_out(portf_out), .portc_in(portc_in), .portc_sync_out(portc_sync_out),
		.rw_out(rw_out));

	oms_ext_mem u_oms_ext_mem (.ref_clk_in(ref_clk_in), .addr_hi_in(portb_out),
		.addr_lo_in(portf_out), .data_in(portc_out), .rw_in(rw_out), .data_out(portc_in));

	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reset is held long enough for the mode pins to clear the synchroniser.
	task automatic do_reset(input logic [1:0] m);
		@(posedge ref_clk_in);
		resetn_in      <= 1'b0;
		mode_sel_hi_in <= m[1];
		mode_sel_lo_in <= m[0];
		repeat (16) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		// Checks that follow read settled outputs, away from the launching edge.
		@(negedge ref_clk_in);
	endtask

	task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		cpu_req_valid_in <= 1'b1;
		cpu_req_in       <= {we, a, d};
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (cpu_ready_out !== 1'b1 && n < 50);
		@(posedge ref_clk_in);
		cpu_req_valid_in <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (cpu_done_out !== 1'b1 && n < 20);
		q = cpu_rdata_out;
		chk("bus done", {15'h0000, cpu_done_out}, 16'h0001);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input string what, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(what, {8'h00, q}, {8'h00, exp});
	endtask

	task automatic send_byte(input logic [7:0] b);
		@(posedge ref_clk_in);
		rx_valid_in <= 1'b1;
		rx_data_in  <= b;
		@(posedge ref_clk_in);
		rx_valid_in <= 1'b0;
	endtask

	task automatic wait_start(output int n);
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (start_valid_out !== 1'b1 && n < IDLE * 3);
	endtask

	task automatic t_modes;
		logic [3:0] exp_mode [4];
		exp_mode = '{4'b0001, 4'b0010, 4'b0100, 4'b1000};
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1:0]);
			chk("mode", {12'h000, mode_out}, {12'h000, exp_mode[m]});
		end
		mode_sel_hi_in <= 1'b0;
		mode_sel_lo_in <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		chk("mode held", {12'h000, mode_out}, 16'h0008);
	endtask

	task automatic t_single;
		do_reset(2'b10);
		chk("port b", portb_out, gpio_b_in);
		chk("port c", portc_out, gpio_c_in);
		chk("port f", portf_out, gpio_f_in);
		rd("unmapped", 16'h8000, 8'h00);
		rd("no rom", 16'hBF00, 8'h00);
		wr(16'h03FF, 8'h3C);
		rd("ram top", 16'h03FF, 8'h3C);
		wr(16'hFE00, 8'hA5);
		rd("eeprom", 16'hFE00, 8'hA5);
	endtask

	task automatic t_expanded;
		do_reset(2'b11);
		wr(16'h1234, 8'hA5);
		chk("ext write", {8'h00, u_oms_ext_mem.mem[16'h1234]}, 16'h00A5);
		rd("ext read", 16'h1234, 8'hA5);
		chk("port c sync", {8'h00, portc_sync_out}, 16'h00A5);
		wr(16'h0010, 8'h77);
		rd("ram same", 16'h0010, 8'h77);
		wr(16'hBF00, 8'h5E);
		chk("rom off", {8'h00, u_oms_ext_mem.mem[16'hBF00]}, 16'h005E);
		wr(16'h103F, 8'h00);
		chk("cfg locked", {8'h00, config_out}, 16'h0001);
	endtask

	task automatic t_test;
		do_reset(2'b01);
		wr(16'h103F, 8'h00);
		chk("cfg write", {8'h00, config_out}, 16'h0000);
		wr(16'hFE00, 8'h11);
		chk("ee off ext", {8'h00, u_oms_ext_mem.mem[16'hFE00]}, 16'h0011);
	endtask

	task automatic t_boot_idle;
		int n;
		do_reset(2'b00);
		chk("entry", loader_entry_out, 16'hBF00);
		chk("held", {15'h0000, cpu_hold_out}, 16'h0001);
		chk("serial on", {15'h0000, async_serial_unit_en_out}, 16'h0001);
		chk("wired or", {15'h0000, portd_wired_or_out}, 16'h0001);
		send_byte(8'hFF);
		send_byte(8'h11);
		send_byte(8'h22);
		send_byte(8'h33);
		wait_start(n);
		chk("idle wait", {15'h0000, n >= IDLE - 2 && n <= IDLE + 2}, 16'h0001);
		chk("start pc", start_pc_out, 16'h0000);
		chk("released", {15'h0000, cpu_hold_out}, 16'h0000);
		rd("ram 0", 16'h0000, 8'h11);
		rd("ram 2", 16'h0002, 8'h33);
		rd("vec hi", 16'hBFC0, 8'h00);
		rd("vec lo", 16'hBFC1, 8'hC4);
		rd("vec1 lo", 16'hBFC3, 8'hC7);
		rd("rst hi", 16'hBFFE, 8'hBF);
		rd("rst redir", 16'hFFFE, 8'hBF);
		rd("rom fill", 16'hBF10, 8'h01);
		rd("unmapped", 16'h8000, 8'h00);
	endtask

	task automatic t_boot_full;
		int n;
		do_reset(2'b00);
		send_byte(8'hFF);
		for (int i = 0; i < 1024; i++) begin
			send_byte(i[7:0] ^ 8'h5A);
		end
		wait_start(n);
		chk("full start", {15'h0000, n <= 2}, 16'h0001);
		send_byte(8'hEE);
		rd("ram 3FF", 16'h03FF, 8'hA5);
		rd("ram 0", 16'h0000, 8'h5A);
	endtask

	initial begin
		errors           = 0;
		compares         = 0;
		resetn_in        = 1'b0;
		mode_sel_hi_in   = 1'b1;
		mode_sel_lo_in   = 1'b0;
		cpu_req_valid_in = 1'b0;
		cpu_req_in       = '0;
		rx_valid_in      = 1'b0;
		rx_data_in       = 8'h00;
		gpio_b_in        = {8'h5A, 8'h0F};
		gpio_c_in        = {8'hC3, 8'hF0};
		gpio_f_in        = {8'h96, 8'h3C};
		repeat (16) @(posedge ref_clk_in);
		t_modes();
		t_single();
		t_expanded();
		t_test();
		t_boot_idle();
		t_boot_full();
		final_report();
	end

	// The longest run, the full download, needs a little over 2000 cycles.
	initial begin
		repeat (40000) @(posedge ref_clk_in);
		errors++;
		$display("mismatch watchdog expected finish seen timeout");
		final_report();
	end
endmodule
